// *** src/lcas_cfg.svh ***
`ifndef LCAS_CFG_SVH
`define LCAS_CFG_SVH
`define LCAS_NUM_CH 3
`define LCAS_CHG_ADDR_CH0 8'h02
`define LCAS_CHG_ADDR_CH1 8'h0a
`define LCAS_CHG_ADDR_CH2 8'h12
`define LCAS_ALM_ADDR_CH0 8'h03
`define LCAS_ALM_ADDR_CH1 8'h0b
`define LCAS_ALM_ADDR_CH2 8'h13
`define LCAS_BIT_DRIVE 0
`define LCAS_BIT_SIGNAL 1
`define LCAS_BIT_UNLOCKED 2
`define LCAS_BIT_FIFO 3
`define LCAS_BIT_ANALOG 4
`define LCAS_BIT_DIGITAL 5
`define LCAS_BIT_PRBS 6
`define LCAS_REG_RESET 8'h00
`define LCAS_PRBS_WINDOW 8'hff
`define LCAS_PRBS_LOSE_ERRS 8'h10
`define LCAS_PRBS_GAIN_ERRS 8'h02
`define LCAS_PRBS_ERR_MAX 8'hff
`endif

// *** src/lcas_channel_alarm_status.sv ***
// Functional notes
// R1: a change of the receive signal-absent state sets change bit 1; a read clears it.
// R2: a change of the drive monitor flag sets change bit 0; a read clears it.
// R3: each change bit reads 1 if its event happened at least once since the last read, else 0.
// R4: alarm status bit 1 shows the present receive signal-absent state.
// R5: alarm status bit 0 shows the present drive monitor flag.
// R6: alarm status of channels 0, 1 and 2 sits at addresses 0x03, 0x0b and 0x13.
// R7: alarm bits 7..0: unused, prbs unlock, digital, analog, fifo, unlocked, absent, drive.
// R8: alarm status is read-only and reads all zero after reset.
// R9: the prbs checker declares loss of lock on a very large number of bit errors.
// R10: the prbs checker clears loss of lock when it sees its pattern with few or no errors.
// R11: bit 6 reads 0 while the prbs checker is locked and 1 while it has lost lock.
// R12: software trusts the prbs lock bit only with the generator on and a line loopback.
// R13: with its enable set, the interrupt output rises on each signal-absent or drive change.
// R14: the receive signal-absent state is the OR of the analog and digital detector outputs.
// R15: a change in the same cycle as a change register read stays latched for the next read.
`timescale 1ns/100ps
`default_nettype none
`include "lcas_cfg.svh"

// sticky event flag: a read clears it, an event in the same cycle wins
module lcas_change_latch (
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic event_in,
   input wire logic clear_in,
   output logic flag_out,
   output logic next_flag_out
);
   import lcas_pkg::*;

   typedef struct packed {
      logic flag;
   } lcas_latch_s;

   lcas_latch_s st;
   lcas_latch_s next_st;

   always_comb begin
      next_st = st;
      if (clear_in) begin
         next_st.flag = 1'b0; // [R3]
      end
      if (event_in) begin
         next_st.flag = 1'b1; // [R15]
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign flag_out = st.flag;
   assign next_flag_out = next_st.flag;
endmodule : lcas_change_latch

// prbs lock tracker: errors are judged once per window of checked bits
module lcas_prbs_lock (
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic bit_valid_in,
   input wire logic bit_error_in,
   output logic unlocked_out
);
   import lcas_pkg::*;

   lcas_prbs_s st;
   lcas_prbs_s next_st;

   always_comb begin
      next_st = st;
      if (bit_valid_in) begin
         // saturate so a long error burst cannot wrap back to a low count
         if (bit_error_in && (st.err_cnt != `LCAS_PRBS_ERR_MAX)) begin
            next_st.err_cnt = st.err_cnt + 8'h01;
         end
         if (st.win_cnt == `LCAS_PRBS_WINDOW) begin
            if (next_st.err_cnt >= `LCAS_PRBS_LOSE_ERRS) begin
               next_st.unlocked = 1'b1; // [R9]
            end else if (next_st.err_cnt <= `LCAS_PRBS_GAIN_ERRS) begin
               next_st.unlocked = 1'b0; // [R10]
            end
            next_st.win_cnt = 8'h00;
            next_st.err_cnt = 8'h00;
         end else begin
            next_st.win_cnt = st.win_cnt + 8'h01;
         end
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign unlocked_out = st.unlocked; // [R11]
endmodule : lcas_prbs_lock

// one channel: live alarm snapshot, two change latches and the prbs tracker
module lcas_channel_slice #(
   parameter int CHANNEL_INDEX = 0
) (
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire lcas_pkg::lcas_ch_in_s ch_in,
   input wire logic signal_int_enable_in,
   input wire logic drive_int_enable_in,
   input wire lcas_pkg::lcas_rd_req_s rd_req_in,
   output lcas_pkg::lcas_byte_t rd_data_out,
   output logic irq_term_out
);
   import lcas_pkg::*;

   localparam lcas_byte_t CHG_ADDR = (CHANNEL_INDEX == 0) ? `LCAS_CHG_ADDR_CH0
      : (CHANNEL_INDEX == 1) ? `LCAS_CHG_ADDR_CH1 : `LCAS_CHG_ADDR_CH2;
   localparam lcas_byte_t ALM_ADDR = (CHANNEL_INDEX == 0) ? `LCAS_ALM_ADDR_CH0
      : (CHANNEL_INDEX == 1) ? `LCAS_ALM_ADDR_CH1 : `LCAS_ALM_ADDR_CH2; // [R6]

   typedef struct packed {
      lcas_byte_t alarm;
   } lcas_slice_s;

   lcas_slice_s st;
   lcas_slice_s next_st;
   logic rd_chg;
   logic rd_alm;
   logic sig_now;
   logic prbs_unlocked;
   logic sig_chg;
   logic drv_chg;
   logic next_sig_chg;
   logic next_drv_chg;

   assign rd_chg = rd_req_in.rd && (rd_req_in.addr == CHG_ADDR);
   assign rd_alm = rd_req_in.rd && (rd_req_in.addr == ALM_ADDR); // [R6]
   assign sig_now = ch_in.analog_signal_absent | ch_in.digital_signal_absent; // [R14]

   lcas_prbs_lock u_prbs (
      .clk_sys_in(clk_sys_in),
      .sys_rst_in(sys_rst_in),
      .bit_valid_in(ch_in.prbs_bit_valid),
      .bit_error_in(ch_in.prbs_bit_error),
      .unlocked_out(prbs_unlocked)
   );

   // change events compare the live level with the registered snapshot
   lcas_change_latch u_signal_chg (
      .clk_sys_in(clk_sys_in),
      .sys_rst_in(sys_rst_in),
      .event_in(sig_now != st.alarm[`LCAS_BIT_SIGNAL]), // [R1]
      .clear_in(rd_chg),
      .flag_out(sig_chg),
      .next_flag_out(next_sig_chg)
   );

   lcas_change_latch u_drive_chg (
      .clk_sys_in(clk_sys_in),
      .sys_rst_in(sys_rst_in),
      .event_in(ch_in.drive_monitor_flag != st.alarm[`LCAS_BIT_DRIVE]), // [R2]
      .clear_in(rd_chg),
      .flag_out(drv_chg),
      .next_flag_out(next_drv_chg)
   );

   always_comb begin
      next_st = st;
      next_st.alarm = `LCAS_REG_RESET; // [R7] [R8]
      next_st.alarm[`LCAS_BIT_DRIVE] = ch_in.drive_monitor_flag; // [R5]
      next_st.alarm[`LCAS_BIT_SIGNAL] = sig_now; // [R4]
      next_st.alarm[`LCAS_BIT_UNLOCKED] = ch_in.clock_recovery_unlocked; // [R7]
      next_st.alarm[`LCAS_BIT_FIFO] = ch_in.fifo_limit_alarm; // [R7]
      next_st.alarm[`LCAS_BIT_ANALOG] = ch_in.analog_signal_absent; // [R7]
      next_st.alarm[`LCAS_BIT_DIGITAL] = ch_in.digital_signal_absent; // [R7]
      next_st.alarm[`LCAS_BIT_PRBS] = prbs_unlocked; // [R11]
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // read contribution stays zero unless this channel is addressed
   always_comb begin
      rd_data_out = `LCAS_REG_RESET;
      if (rd_chg) begin
         rd_data_out = {6'h00, sig_chg, drv_chg}; // [R1] [R2]
      end
      if (rd_alm) begin
         rd_data_out = st.alarm; // [R8]
      end
   end

   // taken from the next change state so irq moves with the change bits
   assign irq_term_out = (next_sig_chg & signal_int_enable_in) // [R13]
      | (next_drv_chg & drive_int_enable_in); // [R13]
endmodule : lcas_channel_slice

module lcas_channel_alarm_status (
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire lcas_pkg::lcas_ch_in_s [2:0] ch_in,
   input wire logic [2:0] signal_int_enable_in,
   input wire logic [2:0] drive_int_enable_in,
   input wire lcas_pkg::lcas_rd_req_s rd_req_in,
   output lcas_pkg::lcas_rd_rsp_s rd_rsp_out,
   output logic irq_out
);
   import lcas_pkg::*;

   typedef struct packed {
      lcas_rd_rsp_s rsp;
      logic irq;
   } lcas_state_s;

   lcas_state_s st;
   lcas_state_s next_st;
   lcas_byte_t rd_part [`LCAS_NUM_CH];
   logic irq_part [`LCAS_NUM_CH];

   for (genvar c = 0; c < `LCAS_NUM_CH; c++) begin : g_ch
      lcas_channel_slice #(
         .CHANNEL_INDEX(c)
      ) u_slice (
         .clk_sys_in(clk_sys_in),
         .sys_rst_in(sys_rst_in),
         .ch_in(ch_in[c]),
         .signal_int_enable_in(signal_int_enable_in[c]),
         .drive_int_enable_in(drive_int_enable_in[c]),
         .rd_req_in(rd_req_in),
         .rd_data_out(rd_part[c]),
         .irq_term_out(irq_part[c])
      );
   end

   // every read answers one cycle later; unmapped addresses read zero
   always_comb begin
      next_st = st;
      next_st.rsp.valid = rd_req_in.rd; // [R6]
      next_st.rsp.data = rd_part[0] | rd_part[1] | rd_part[2]; // [R8]
      next_st.irq = irq_part[0] | irq_part[1] | irq_part[2]; // [R13]
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign rd_rsp_out = st.rsp;
   assign irq_out = st.irq;
endmodule : lcas_channel_alarm_status
`default_nettype wire

// *** src/lcas_pkg.sv ***
`default_nettype none
package lcas_pkg;
   typedef logic [7:0] lcas_byte_t;
   typedef struct packed {
      logic drive_monitor_flag;
      logic analog_signal_absent;
      logic digital_signal_absent;
      logic clock_recovery_unlocked;
      logic fifo_limit_alarm;
      logic prbs_bit_valid;
      logic prbs_bit_error;
   } lcas_ch_in_s;
   typedef struct packed {
      logic [7:0] addr;
      logic rd;
   } lcas_rd_req_s;
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } lcas_rd_rsp_s;
   typedef struct packed {
      logic [7:0] win_cnt;
      logic [7:0] err_cnt;
      logic unlocked;
   } lcas_prbs_s;
endpackage : lcas_pkg
`default_nettype wire

// *** tb/lcas_chk_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
module lcas_chk (
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire lcas_pkg::lcas_ch_in_s [2:0] ch_in,
   input wire logic [2:0] signal_int_enable_in,
   input wire logic [2:0] drive_int_enable_in,
   input wire lcas_pkg::lcas_rd_req_s rd_req_in,
   input wire lcas_pkg::lcas_rd_rsp_s rd_rsp_out,
   input wire logic irq_out
);
   import lcas_pkg::*;
   logic sig1;
   logic drv;
   assign sig1 = ch_in[1].analog_signal_absent | ch_in[1].digital_signal_absent;
   assign drv = ch_in[0].drive_monitor_flag;
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (sys_rst_in);
   sequence s_rd(a);
      rd_req_in.rd && rd_req_in.addr == a;
   endsequence
   AST_ANSWER: assert property (rd_req_in.rd |=> rd_rsp_out.valid) else $error("answer");
   AST_IDLE: assert property (!rd_req_in.rd |=> rd_rsp_out == '0) else $error("idle");
   AST_DRIVE: assert property (s_rd(8'h03) |=> rd_rsp_out.data[0] == $past(drv, 2))
      else $error("drive");
   AST_SIGNAL: assert property (s_rd(8'h0b) |=> rd_rsp_out.data[1] == $past(sig1, 2))
      else $error("signal");
   AST_LAYOUT: assert property (s_rd(8'h13) |=> !rd_rsp_out.data[7] &&
      rd_rsp_out.data[5:2] == {$past(ch_in[2].digital_signal_absent, 2),
      $past(ch_in[2].analog_signal_absent, 2),
      $past(ch_in[2].fifo_limit_alarm, 2), $past(ch_in[2].clock_recovery_unlocked, 2)})
      else $error("layout");
   AST_DRV_CHG: assert property (s_rd(8'h02) ##0 $past(drv) != $past(drv, 2)
      |=> rd_rsp_out.data[0]) else $error("drive change");
   AST_SIG_CHG: assert property (s_rd(8'h0a) ##0 $past(sig1) != $past(sig1, 2)
      |=> rd_rsp_out.data[1]) else $error("signal change");
   AST_IRQ: assert property ($past(drive_int_enable_in[0]) && $past(drv) != $past(drv, 2)
      |-> irq_out) else $error("irq");
   AST_IRQ_SIG: assert property ($past(signal_int_enable_in[1]) && $past(sig1) != $past(sig1, 2)
      |-> irq_out) else $error("irq signal");
endmodule : lcas_chk
bind lcas_channel_alarm_status lcas_chk chk (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
   .ch_in(ch_in), .signal_int_enable_in(signal_int_enable_in),
   .drive_int_enable_in(drive_int_enable_in), .rd_req_in(rd_req_in),
   .rd_rsp_out(rd_rsp_out), .irq_out(irq_out));
`default_nettype wire

// *** tb/test_lcas_channel_alarm_status.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
   $display("MISMATCH %0t %h %h", $time, a, b); end end
module test_lcas_channel_alarm_status;
   import lcas_pkg::*;
   logic clk_sys_in = 0;
   logic sys_rst_in = 1;
   lcas_ch_in_s [2:0] ch = '0;
   logic [2:0] sen = '0;
   logic [2:0] den = '0;
   lcas_rd_req_s req = '0;
   lcas_rd_rsp_s rsp;
   logic irq;
   int bad_count = 0;
   int tests_run = 0;
   always #5 clk_sys_in = ~clk_sys_in;
   lcas_channel_alarm_status uut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .ch_in(ch),
      .signal_int_enable_in(sen), .drive_int_enable_in(den), .rd_req_in(req),
      .rd_rsp_out(rsp), .irq_out(irq));
   task automatic rd(input lcas_byte_t a, input lcas_byte_t e);
      @(negedge clk_sys_in) req = '{a, 1'b1};
      @(negedge clk_sys_in) req.rd = 1'b0;
      `CHK(rsp.valid, 1'b1)
      `CHK(rsp.data, e)
   endtask : rd
   task automatic t_reset;
      lcas_byte_t adr[7] = '{8'h02, 8'h03, 8'h0a, 8'h0b, 8'h12, 8'h13, 8'h04};
      foreach (adr[i]) rd(adr[i], 8'h00);
      $display("test reset done");
   endtask : t_reset
   task automatic t_alarm;
      @(negedge clk_sys_in) den = 3'b001;
      ch[0].drive_monitor_flag = 1'b1;
      ch[1].analog_signal_absent = 1'b1;
      ch[2] = 7'b0011100;
      repeat (2) @(negedge clk_sys_in);
      `CHK(irq, 1'b1)
      rd(8'h03, 8'h01);
      rd(8'h0b, 8'h12);
      rd(8'h13, 8'h2e);
      rd(8'h02, 8'h01);
      `CHK(irq, 1'b0)
      rd(8'h02, 8'h00);
      rd(8'h0a, 8'h02);
      rd(8'h12, 8'h02);
      rd(8'h0a, 8'h00);
      $display("test alarm done");
   endtask : t_alarm
   task automatic t_setwin;
      @(negedge clk_sys_in) req = '{8'h02, 1'b1};
      ch[0].drive_monitor_flag = 1'b0;
      @(negedge clk_sys_in) req.rd = 1'b0;
      `CHK(rsp.data, 8'h00)
      rd(8'h02, 8'h01);
      $display("test setwin done");
   endtask : t_setwin
   task automatic feed(input int errs);
      for (int i = 0; i < 256; i++) begin
         @(negedge clk_sys_in) ch[0].prbs_bit_valid = 1'b1;
         ch[0].prbs_bit_error = (i < errs);
      end
      @(negedge clk_sys_in) ch[0].prbs_bit_valid = 1'b0;
   endtask : feed
   task automatic t_prbs;
      int errs[4] = '{15, 16, 3, 2};
      lcas_byte_t want[4] = '{8'h00, 8'h40, 8'h40, 8'h00};
      foreach (errs[i]) begin
         feed(errs[i]);
         rd(8'h03, want[i]);
      end
      $display("test prbs done");
   endtask : t_prbs
   task automatic t_irq;
      @(negedge clk_sys_in) den = 3'b000;
      sen = 3'b010;
      ch[1].digital_signal_absent = 1'b1;
      repeat (2) @(negedge clk_sys_in);
      `CHK(irq, 1'b0)
      rd(8'h0b, 8'h32);
      ch[1].analog_signal_absent = 1'b0;
      repeat (2) @(negedge clk_sys_in);
      `CHK(irq, 1'b0)
      ch[1].digital_signal_absent = 1'b0;
      repeat (2) @(negedge clk_sys_in);
      `CHK(irq, 1'b1)
      rd(8'h0a, 8'h02);
      `CHK(irq, 1'b0)
      $display("test irq done");
   endtask : t_irq
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : end_of_test
   initial begin
      repeat (3) @(negedge clk_sys_in);
      sys_rst_in = 1'b0;
      t_reset();
      t_alarm();
      t_setwin();
      t_prbs();
      t_irq();
      end_of_test();
   end
endmodule : test_lcas_channel_alarm_status
`default_nettype wire
